//--- hdl/link_codec_consts.vh
// Purpose: shared constants of the parallel/serial link codec
// Assumes: one 20 MHz clock, serial bit rate derived by a divider
// Notes: symbol codes are left-justified in a 12-bit code word
//
// Overview of operation
// - eight-bit mode splits the byte into two nibbles, each coded into five bits.
// - encoded bytes are NRZI formatted before leaving on the serial line.
// - accepted words are latched, encoded, then shifted out at bit rate.
// - host strobes each word; transmitter answers an accepted strobe with acknowledge.
// - data or command symbols go out only for byte cycles with a strobed word.
// - byte cycles without a strobed word send the unique Sync symbol.
// - receiver finds byte boundaries by detecting the Sync symbol.
// - a decoded Sync leaves output lines alone and raises no strobe.
// - receiver strobes whenever a new data or command word is on its outputs.
// - receiver recovers the bit clock by tracking line transitions, samples with it.
// - both ends have twelve parallel lines, each a data or command bit.
// - line split is selectable as 8+4, 9+3 or 10+2.
// - commands travel as distinct symbols, distinguishable from data.
// - local mode links exactly one transmitter to one receiver over one line.
// - test mode bypasses internal clocking and tracking, using an external bit clock.
// - nine-bit mode uses a 5-to-6 upper coder; ten-bit mode uses two.
// - any nonzero command bit at strobe sends a command, ignoring data lines.
// - NRZI gives a transition for each one bit, none for zero.
// - serializer sends the most significant bit of the upper field first.
`ifndef LINK_CODEC_CONSTS_VH
`define LINK_CODEC_CONSTS_VH

// width modes on the width_mode pins
`define MODE_8 2'h0
`define MODE_9 2'h1
`define MODE_10 2'h2

// code bits per byte in each mode
`define NBITS_8 4'ha
`define NBITS_9 4'hb
`define NBITS_10 4'hc

// last sys_clk count of a serial bit (8 cycles a bit), and the sampling phase inside a bit
`define BIT_DIV_LAST 4'h7
`define BIT_MID 4'h4

// sync and command field codes, all outside the data code sets
`define SYNC5_HI 5'h18
`define SYNC5_LO 5'h11
`define SYNC6 6'h06
`define CMD5 5'h07
`define CMD6 6'h07

// line masks for data and command bits
`define DMASK_8 12'h0ff
`define DMASK_9 12'h1ff
`define DMASK_10 12'h3ff
`define CMASK_8 12'hf00
`define CMASK_9 12'he00
`define CMASK_10 12'hc00

`endif

//--- hdl/nrzi_serializer.v
// Purpose: parallel-to-serial shifter with NRZI line formatting
// Assumes: bit_en is a one-cycle pulse at the serial bit rate
// Notes: take pulses when the next code word is loaded
`timescale 1ns/1ps
`default_nettype none
module nrzi_serializer (
  // clock and reset
  input wire sys_clk,
  input wire rst_n,
  // bit timing and word length
  input wire bit_en,
  input wire [3:0] nbits,
  // code word and load pulse
  input wire [11:0] code,
  output wire take,
  // serial line
  output reg line_reg
);

  reg [11:0] shift_reg;
  reg [3:0] cnt_reg;
  wire cur_bit;

  // byte boundary when the count runs out
  assign take = bit_en && (cnt_reg == 4'h0);
  assign cur_bit = take ? code[11] : shift_reg[11];

  // shifter and nrzi toggle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 12'h000;
      cnt_reg <= 4'h0;
      line_reg <= 1'b0;
    end else if (bit_en) begin
      line_reg <= line_reg ^ cur_bit;
      if (take) begin
        shift_reg <= {code[10:0], 1'b0};
        cnt_reg <= nbits - 4'h1;
      end else begin
        shift_reg <= {shift_reg[10:0], 1'b0};
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end

endmodule // nrzi_serializer
`default_nettype wire

//--- hdl/link_codec_top.v
// Purpose: transmitter and receiver of a 12-line parallel-over-serial link
// Assumes: host inputs and serial line are asynchronous to sys_clk
// Notes: width mode pins should only change while the link is idle
`timescale 1ns/1ps
`default_nettype none
`include "link_codec_consts.vh"
module link_codec_top (
  // clock and reset
  input wire sys_clk,
  input wire nrst,
  // mode pins
  input wire [1:0] width_mode,
  input wire test_mode,
  input wire test_bit_clk,
  // host transmit side
  input wire [11:0] tx_lines,
  input wire tx_strb,
  output reg tx_ack_reg,
  // serial line
  output wire serial_out,
  input wire serial_in,
  // host receive side
  output reg [11:0] rx_lines_reg,
  output reg rx_data_strb_reg,
  output reg rx_cmd_strb_reg,
  output reg rx_locked_reg
);

  // 4b/5b data code
  function [4:0] enc4;
    input [3:0] d;
    case (d)
      4'h0: enc4 = 5'h1e; 4'h1: enc4 = 5'h09; 4'h2: enc4 = 5'h14; 4'h3: enc4 = 5'h15;
      4'h4: enc4 = 5'h0a; 4'h5: enc4 = 5'h0b; 4'h6: enc4 = 5'h0e; 4'h7: enc4 = 5'h0f;
      4'h8: enc4 = 5'h12; 4'h9: enc4 = 5'h13; 4'ha: enc4 = 5'h16; 4'hb: enc4 = 5'h17;
      4'hc: enc4 = 5'h1a; 4'hd: enc4 = 5'h1b; 4'he: enc4 = 5'h1c; default: enc4 = 5'h1d;
    endcase
  endfunction

  // 5b/6b data code
  function [5:0] enc6;
    input [4:0] d;
    case (d)
      5'h00: enc6 = 6'h36; 5'h01: enc6 = 6'h11; 5'h02: enc6 = 6'h24; 5'h03: enc6 = 6'h25;
      5'h04: enc6 = 6'h12; 5'h05: enc6 = 6'h13; 5'h06: enc6 = 6'h16; 5'h07: enc6 = 6'h17;
      5'h08: enc6 = 6'h22; 5'h09: enc6 = 6'h31; 5'h0a: enc6 = 6'h37; 5'h0b: enc6 = 6'h27;
      5'h0c: enc6 = 6'h32; 5'h0d: enc6 = 6'h33; 5'h0e: enc6 = 6'h34; 5'h0f: enc6 = 6'h35;
      5'h10: enc6 = 6'h3e; 5'h11: enc6 = 6'h19; 5'h12: enc6 = 6'h29; 5'h13: enc6 = 6'h2d;
      5'h14: enc6 = 6'h1a; 5'h15: enc6 = 6'h1b; 5'h16: enc6 = 6'h1e; 5'h17: enc6 = 6'h1f;
      5'h18: enc6 = 6'h2a; 5'h19: enc6 = 6'h2b; 5'h1a: enc6 = 6'h2e; 5'h1b: enc6 = 6'h2f;
      5'h1c: enc6 = 6'h3a; 5'h1d: enc6 = 6'h3b; 5'h1e: enc6 = 6'h3c; default: enc6 = 6'h3d;
    endcase
  endfunction

  // inverse by search, result {valid, 1'b0, value}
  function [5:0] dec4;
    input [4:0] s;
    integer i;
    begin
      dec4 = 6'h00;
      for (i = 0; i < 16; i = i + 1) begin
        if (enc4(i[3:0]) == s) begin
          dec4 = {2'b10, i[3:0]};
        end
      end
    end
  endfunction

  // inverse by search, result {valid, value}
  function [5:0] dec6;
    input [5:0] s;
    integer i;
    begin
      dec6 = 6'h00;
      for (i = 0; i < 32; i = i + 1) begin
        if (enc6(i[4:0]) == s) begin
          dec6 = {1'b1, i[4:0]};
        end
      end
    end
  endfunction

  // reset release and pin synchronisers
  reg [1:0] rst_sync_reg;
  wire rst_n;
  reg [1:0] mode_s1_reg, mode_s2_reg;
  reg test_s1_reg, test_s2_reg;
  reg tck_s1_reg, tck_s2_reg, tck_s3_reg;
  reg strb_s1_reg, strb_s2_reg;
  reg [11:0] lines_s1_reg, lines_s2_reg;
  reg ser_s1_reg, ser_s2_reg, ser_s3_reg;

  assign rst_n = rst_sync_reg[1];

  // async assert, two-stage release
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // every outside input passes two flops before use
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_s1_reg <= `MODE_8;
      mode_s2_reg <= `MODE_8;
      test_s1_reg <= 1'b0;
      test_s2_reg <= 1'b0;
      tck_s1_reg <= 1'b0;
      tck_s2_reg <= 1'b0;
      tck_s3_reg <= 1'b0;
      strb_s1_reg <= 1'b0;
      strb_s2_reg <= 1'b0;
      lines_s1_reg <= 12'h000;
      lines_s2_reg <= 12'h000;
      ser_s1_reg <= 1'b0;
      ser_s2_reg <= 1'b0;
      ser_s3_reg <= 1'b0;
    end else begin
      mode_s1_reg <= width_mode;
      mode_s2_reg <= mode_s1_reg;
      test_s1_reg <= test_mode;
      test_s2_reg <= test_s1_reg;
      tck_s1_reg <= test_bit_clk;
      tck_s2_reg <= tck_s1_reg;
      tck_s3_reg <= tck_s2_reg;
      strb_s1_reg <= tx_strb;
      strb_s2_reg <= strb_s1_reg;
      lines_s1_reg <= tx_lines;
      lines_s2_reg <= lines_s1_reg;
      ser_s1_reg <= serial_in;
      ser_s2_reg <= ser_s1_reg;
      ser_s3_reg <= ser_s2_reg;
    end
  end

  // mode decode: word length, sync code and line masks
  reg [3:0] nbits;
  reg [11:0] sync_code, dmask, cmask;
  always @* begin
    case (mode_s2_reg)
      `MODE_8: begin
        nbits = `NBITS_8;
        sync_code = {`SYNC5_HI, `SYNC5_LO, 2'b00};
        dmask = `DMASK_8;
        cmask = `CMASK_8;
      end
      `MODE_9: begin
        nbits = `NBITS_9;
        sync_code = {`SYNC6, `SYNC5_LO, 1'b0};
        dmask = `DMASK_9;
        cmask = `CMASK_9;
      end
      default: begin
        nbits = `NBITS_10;
        sync_code = {`SYNC6, `SYNC6};
        dmask = `DMASK_10;
        cmask = `CMASK_10;
      end
    endcase
  end

  // bit timing: divider in local mode, external clock edge in test mode
  reg [3:0] div_reg;
  wire tck_rise;
  wire tx_bit_en;
  assign tck_rise = tck_s2_reg & ~tck_s3_reg;
  assign tx_bit_en = test_s2_reg ? tck_rise : (div_reg == `BIT_DIV_LAST);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= (div_reg == `BIT_DIV_LAST) ? 4'h0 : div_reg + 4'h1;
    end
  end

  // strobe/acknowledge input latch; a full latch holds off the ack (busy)
  reg [11:0] tx_word_reg;
  reg tx_full_reg;
  wire tx_take;
  wire tx_accept;
  assign tx_accept = strb_s2_reg && !tx_ack_reg && !tx_full_reg;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_word_reg <= 12'h000;
      tx_full_reg <= 1'b0;
      tx_ack_reg <= 1'b0;
    end else begin
      if (tx_accept) begin
        tx_word_reg <= lines_s2_reg;
      end
      tx_full_reg <= tx_accept ? 1'b1 : (tx_take ? 1'b0 : tx_full_reg);
      tx_ack_reg <= tx_accept ? 1'b1 : (strb_s2_reg & tx_ack_reg);
    end
  end

  // encoder: command wins over data, sync when nothing strobed
  reg [11:0] tx_code;
  reg [3:0] cmd_in;
  wire [9:0] d = tx_word_reg[9:0];
  always @* begin
    case (mode_s2_reg)
      `MODE_8: cmd_in = {tx_word_reg[9], tx_word_reg[8], tx_word_reg[11], tx_word_reg[10]};
      `MODE_9: cmd_in = {1'b0, tx_word_reg[9], tx_word_reg[11], tx_word_reg[10]};
      default: cmd_in = {2'b00, tx_word_reg[11], tx_word_reg[10]};
    endcase
    if (!tx_full_reg) begin
      tx_code = sync_code;
    end else begin
      case (mode_s2_reg)
        `MODE_8: begin
          if (cmd_in != 4'h0) begin
            tx_code = {`CMD5, enc4(cmd_in), 2'b00};
          end else begin
            tx_code = {enc4(d[7:4]), enc4(d[3:0]), 2'b00};
          end
        end
        `MODE_9: begin
          if (cmd_in != 4'h0) begin
            tx_code = {`CMD6, enc4(cmd_in), 1'b0};
          end else begin
            tx_code = {enc6(d[8:4]), enc4(d[3:0]), 1'b0};
          end
        end
        default: begin
          if (cmd_in != 4'h0) begin
            tx_code = {`CMD6, enc6({1'b0, cmd_in})};
          end else begin
            tx_code = {enc6(d[8:4]), enc6({d[9], d[3:0]})};
          end
        end
      endcase
    end
  end

  nrzi_serializer u_ser (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .bit_en(tx_bit_en),
    .nbits(nbits),
    .code(tx_code),
    .take(tx_take),
    .line_reg(serial_out)
  );

  // receive clock recovery: phase counter restarts on every line edge
  reg [3:0] rx_phase_reg;
  reg rx_last_samp_reg;
  wire rx_samp_en;
  assign rx_samp_en = test_s2_reg ? tck_rise : (rx_phase_reg == `BIT_MID);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_phase_reg <= 4'h0;
      rx_last_samp_reg <= 1'b0;
    end else begin
      if (ser_s2_reg != ser_s3_reg) begin
        rx_phase_reg <= 4'h1;
      end else begin
        rx_phase_reg <= (rx_phase_reg == `BIT_DIV_LAST) ? 4'h0 : rx_phase_reg + 4'h1;
      end
      if (rx_samp_en) begin
        rx_last_samp_reg <= ser_s2_reg;
      end
    end
  end

  // nrzi decode and deframing window
  reg [11:0] rx_sh_reg;
  reg [3:0] rx_cnt_reg;
  wire [11:0] rx_sh_next = {rx_sh_reg[10:0], ser_s2_reg ^ rx_last_samp_reg};
  reg [11:0] win;
  always @* begin
    case (mode_s2_reg)
      `MODE_8: win = {rx_sh_next[9:0], 2'b00};
      `MODE_9: win = {rx_sh_next[10:0], 1'b0};
      default: win = rx_sh_next;
    endcase
  end

  // symbol decode into line value, command flag and validity
  reg [5:0] hi_dec, lo_dec;
  reg is_cmd;
  reg [11:0] rx_val;
  always @* begin
    case (mode_s2_reg)
      `MODE_8: begin
        is_cmd = (win[11:7] == `CMD5);
        hi_dec = dec4(win[11:7]);
        lo_dec = dec4(win[6:2]);
        rx_val = is_cmd ? {lo_dec[1], lo_dec[0], lo_dec[3], lo_dec[2], 8'h00}
                        : {4'h0, hi_dec[3:0], lo_dec[3:0]};
      end
      `MODE_9: begin
        is_cmd = (win[11:6] == `CMD6);
        hi_dec = dec6(win[11:6]);
        lo_dec = dec4(win[5:1]);
        rx_val = is_cmd ? {lo_dec[1], lo_dec[0], lo_dec[2], 9'h000}
                        : {3'h0, hi_dec[4:0], lo_dec[3:0]};
      end
      default: begin
        is_cmd = (win[11:6] == `CMD6);
        hi_dec = dec6(win[11:6]);
        lo_dec = dec6(win[5:0]);
        rx_val = is_cmd ? {lo_dec[1], lo_dec[0], 10'h000}
                        : {2'h0, lo_dec[4], hi_dec[4:0], lo_dec[3:0]};
      end
    endcase
  end

  wire rx_sync_hit = (win == sync_code);
  wire rx_valid = lo_dec[5] & (is_cmd | hi_dec[5]);
  wire [11:0] rx_mask = is_cmd ? cmask : dmask;

  // framing, output latch and strobes
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh_reg <= 12'h000;
      rx_cnt_reg <= 4'h0;
      rx_locked_reg <= 1'b0;
      rx_lines_reg <= 12'h000;
      rx_data_strb_reg <= 1'b0;
      rx_cmd_strb_reg <= 1'b0;
    end else begin
      rx_data_strb_reg <= 1'b0;
      rx_cmd_strb_reg <= 1'b0;
      if (rx_samp_en) begin
        rx_sh_reg <= rx_sh_next;
        if (rx_sync_hit) begin
          rx_cnt_reg <= 4'h0;
          rx_locked_reg <= 1'b1;
        end else if (rx_cnt_reg == nbits - 4'h1) begin
          rx_cnt_reg <= 4'h0;
          if (rx_locked_reg && rx_valid) begin
            rx_lines_reg <= (rx_lines_reg & ~rx_mask) | (rx_val & rx_mask);
            rx_data_strb_reg <= ~is_cmd;
            rx_cmd_strb_reg <= is_cmd;
          end else begin
            rx_locked_reg <= 1'b0; // code violation drops framing
          end
        end else begin
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
        end
      end
    end
  end

endmodule // link_codec_top
`default_nettype wire

//--- verification/link_codec_checker_assertions.sv
// Purpose: port-level checker for the link codec top
// Assumes: local mode bit time of 8 sys_clk cycles
// Notes: line timing checks are off in test mode
`timescale 1ns/1ps
`default_nettype none
module link_codec_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // mode and host side
  input wire logic test_mode,
  input wire logic tx_strb,
  input wire logic tx_ack_reg,
  // line and receive side
  input wire logic serial_out,
  input wire logic [11:0] rx_lines_reg,
  input wire logic rx_data_strb_reg,
  input wire logic rx_cmd_strb_reg,
  input wire logic rx_locked_reg
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // host handshake
  ack_after_strb_a: assert property ($rose(tx_ack_reg) |-> $past(tx_strb, 2))
    else $error("ack rose without a held strobe");
  ack_hold_a: assert property (tx_ack_reg && tx_strb |=> tx_ack_reg)
    else $error("ack dropped while strobe held");
  ack_release_a: assert property ($fell(tx_strb) |-> ##[1:4] !tx_ack_reg)
    else $error("ack not released after strobe");
  // receive side
  strb_single_a: assert property (rx_data_strb_reg |=> !rx_data_strb_reg)
    else $error("data strobe longer than one cycle");
  strb_kind_a: assert property (!(rx_data_strb_reg && rx_cmd_strb_reg))
    else $error("data and command strobe together");
  lines_quiet_a: assert property ($changed(rx_lines_reg) |-> rx_data_strb_reg || rx_cmd_strb_reg)
    else $error("lines changed without strobe");
  strb_locked_a: assert property (rx_data_strb_reg || rx_cmd_strb_reg |-> rx_locked_reg)
    else $error("strobe without byte framing");
  // serial line; test mode has its own bit clock
  bit_period_a: assert property (disable iff (!nrst || test_mode)
    $changed(serial_out) |=> $stable(serial_out) [*7]) else $error("bit shorter than 8 cycles");
  line_active_a: assert property (disable iff (!nrst || test_mode)
    1'b1 |-> ##[1:250] $changed(serial_out)) else $error("idle line without sync");
  cover property (rx_data_strb_reg);
  cover property (rx_cmd_strb_reg);
  cover property ($fell(rx_locked_reg));
  cover property ($rose(tx_ack_reg));
endmodule // link_codec_checker
bind link_codec_top link_codec_checker chk (.sys_clk(sys_clk), .nrst(nrst),
  .test_mode(test_mode), .tx_strb(tx_strb), .tx_ack_reg(tx_ack_reg),
  .serial_out(serial_out), .rx_lines_reg(rx_lines_reg), .rx_data_strb_reg(rx_data_strb_reg),
  .rx_cmd_strb_reg(rx_cmd_strb_reg), .rx_locked_reg(rx_locked_reg));
`default_nettype wire

//--- verification/serial_line_model.sv
// Purpose: serial medium between one transmitter and one receiver
// Assumes: delay counted in sys_clk cycles
// Notes: a cut line sits at its pull-down level
`timescale 1ns/1ps
`default_nettype none
module serial_line_model (
  // clock
  input wire logic sys_clk,
  // line ends
  input wire logic line_in,
  output logic line_out,
  // delay and fault
  input wire logic [3:0] lag,
  input wire logic cut
);
  logic [15:0] pipe_reg = 16'h0000;
  // delay line, lets the receiver track a slow path
  always @(posedge sys_clk) begin
    pipe_reg <= {pipe_reg[14:0], line_in};
  end
  assign line_out = cut ? 1'b0 : pipe_reg[lag];
endmodule // serial_line_model
`default_nettype wire

//--- verification/parallel_serial_link_codec_test.sv
// Purpose: loopback test of the link codec through a line model
// Assumes: 20 MHz sys_clk, bit time 8 cycles
// Notes: expected fields derive from the line masks
`timescale 1ns/1ps
`default_nettype none
`include "link_codec_consts.vh"
module parallel_serial_link_codec_test;
  logic sys_clk, nrst, test_mode, test_bit_clk, tx_strb, tx_ack_reg, cut;
  logic serial_out, serial_in, rx_data_strb_reg, rx_cmd_strb_reg, rx_locked_reg;
  logic [1:0] width_mode, tb_cnt = 2'h0;
  logic [11:0] tx_lines, rx_lines_reg, dm, cm, prev;
  logic [12:0] w;
  logic [3:0] lag;
  logic [12:0] rx_q[$];
  int n_fail = 0, n_compared = 0, r;
  // rows: {is command, mode, lines}
  logic [14:0] rows[10] = '{15'h00a5, 15'h00ff, 15'h43c0, 15'h4f00, 15'h11ff, 15'h5200,
    15'h113a, 15'h23ff, 15'h2000, 15'h68e7};
  link_codec_top uut (.sys_clk(sys_clk), .nrst(nrst), .width_mode(width_mode),
    .test_mode(test_mode), .test_bit_clk(test_bit_clk), .tx_lines(tx_lines),
    .tx_strb(tx_strb), .tx_ack_reg(tx_ack_reg), .serial_out(serial_out),
    .serial_in(serial_in), .rx_lines_reg(rx_lines_reg), .rx_data_strb_reg(rx_data_strb_reg),
    .rx_cmd_strb_reg(rx_cmd_strb_reg), .rx_locked_reg(rx_locked_reg));
  serial_line_model line (.sys_clk(sys_clk), .line_in(serial_out), .line_out(serial_in),
    .lag(lag), .cut(cut));
  always #25 sys_clk = ~sys_clk;
  // external bit clock, 8 cycles a bit, only in test mode
  always @(posedge sys_clk) begin
    tb_cnt <= tb_cnt + 2'h1;
    if (test_mode && tb_cnt == 2'h3) test_bit_clk <= ~test_bit_clk;
  end
  // strobes are one cycle, so every edge is watched
  always @(posedge sys_clk) begin
    if (rx_data_strb_reg === 1'b1 || rx_cmd_strb_reg === 1'b1)
      rx_q.push_back({rx_cmd_strb_reg, rx_lines_reg});
  end
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task check_lines(input logic [11:0] got, input logic [11:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wait_lock(input logic lvl);
    int i;
    for (i = 0; i < 3000 && rx_locked_reg !== lvl; i++) @(posedge sys_clk);
    check_bit(rx_locked_reg, lvl);
    if (rx_locked_reg !== lvl) test_done();
  endtask
  // four-phase word hand-over; lines settle a cycle before the strobe
  task send(input logic [11:0] v);
    int i;
    tx_lines <= v;
    @(posedge sys_clk);
    tx_strb <= 1'b1;
    for (i = 0; i < 400 && tx_ack_reg !== 1'b1; i++) @(posedge sys_clk);
    check_bit(tx_ack_reg, 1'b1);
    tx_strb <= 1'b0;
    for (i = 0; i < 20 && tx_ack_reg !== 1'b0; i++) @(posedge sys_clk);
    check_bit(tx_ack_reg, 1'b0);
  endtask
  task get_word;
    int i;
    for (i = 0; i < 1500 && rx_q.size() == 0; i++) @(posedge sys_clk);
    check_bit(rx_q.size() != 0, 1'b1);
    if (rx_q.size() == 0) test_done();
    else w = rx_q.pop_front();
  endtask
  // send one data word and compare its data field
  task round_trip(input logic [11:0] v);
    send(v);
    get_word();
    check_lines(w[11:0] & dm, v & dm);
  endtask
  initial begin
    sys_clk = 1'b0;
    nrst = 1'b0;
    width_mode = `MODE_8;
    test_mode = 1'b0;
    test_bit_clk = 1'b0;
    tx_lines = 12'h000;
    tx_strb = 1'b0;
    lag = 4'h2;
    cut = 1'b0;
    repeat (8) @(posedge sys_clk);
    check_bit(rx_data_strb_reg | rx_cmd_strb_reg | tx_ack_reg | rx_locked_reg, 1'b0);
    nrst <= 1'b1;
    for (r = 0; r < 10; r++) begin
      if (rows[r][13:12] !== width_mode || r == 0) begin
        width_mode <= rows[r][13:12];
        repeat (400) @(posedge sys_clk);
        wait_lock(1'b1);
        rx_q.delete();
      end
      dm = rows[r][13] ? `DMASK_10 : (rows[r][12] ? `DMASK_9 : `DMASK_8);
      cm = ~dm;
      send(rows[r][11:0]);
      get_word();
      check_bit(w[12], rows[r][14]);
      if (rows[r][14]) begin
        check_lines(w[11:0] & cm, rows[r][11:0] & cm);
        check_lines(w[11:0] & dm, prev & dm);
      end else begin
        check_lines(w[11:0] & dm, rows[r][11:0] & dm);
      end
      prev = w[11:0];
      $display("row %0d done", r);
    end
    // idle bytes carry sync only
    repeat (300) @(posedge sys_clk);
    check_bit(rx_q.size() != 0, 1'b0);
    check_lines(rx_lines_reg, prev);
    $display("idle test done");
    // back-to-back words keep their order
    send(12'h155);
    send(12'h2aa);
    get_word();
    check_lines(w[11:0] & dm, 12'h155);
    get_word();
    check_lines(w[11:0] & dm, 12'h2aa);
    $display("back-to-back test done");
    // slow line path
    lag <= 4'hd;
    repeat (200) @(posedge sys_clk);
    rx_q.delete();
    round_trip(12'h0c3);
    $display("slow line test done");
    // broken line loses framing, sync regains it
    cut <= 1'b1;
    wait_lock(1'b0);
    cut <= 1'b0;
    wait_lock(1'b1);
    rx_q.delete();
    round_trip(12'h301);
    $display("line cut test done");
    // external bit clock
    test_mode <= 1'b1;
    repeat (400) @(posedge sys_clk);
    wait_lock(1'b1);
    rx_q.delete();
    round_trip(12'h1e4);
    $display("test mode test done");
    test_done();
  end
endmodule // parallel_serial_link_codec_test
`default_nettype wire
